// >>> design/iccs_pkg.sv
// Constants, types and register map of the interrupt command and status block.
package iccs_pkg;

    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 12;
    localparam int NUM_SRC = 32;
    localparam int SRC_W   = 5;
    localparam int EVT_W   = 3;

    localparam logic [ADDR_W-1:0] OFS_NORMAL_VEC  = 12'h100;
    localparam logic [ADDR_W-1:0] OFS_FAST_VEC    = 12'h104;
    localparam logic [ADDR_W-1:0] OFS_CUR_NUM     = 12'h108;
    localparam logic [ADDR_W-1:0] OFS_PENDING     = 12'h10C;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_MASK = 12'h110;
    localparam logic [ADDR_W-1:0] OFS_CORE_LINE   = 12'h114;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_CMD  = 12'h120;
    localparam logic [ADDR_W-1:0] OFS_DISABLE_CMD = 12'h124;
    localparam logic [ADDR_W-1:0] OFS_CLEAR_CMD   = 12'h128;
    localparam logic [ADDR_W-1:0] OFS_SET_CMD     = 12'h12C;
    localparam logic [ADDR_W-1:0] OFS_EOS_CMD     = 12'h130;
    localparam logic [ADDR_W-1:0] OFS_SPURIOUS    = 12'h134;
    localparam logic [ADDR_W-1:0] OFS_DEBUG       = 12'h138;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS  = 12'h150;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK    = 12'h154;

    localparam int DBG_PROTECTION_MODE_BIT = 0;
    localparam int DBG_GLOBAL_LINE_MASK_BIT = 1;
    localparam int CORE_FAST_BIT   = 0;
    localparam int CORE_NORMAL_BIT = 1;
    localparam int FAST_SRC        = 0;

    localparam int EVT_EOS_BIT      = 0;
    localparam int EVT_SPUR_NRM_BIT = 1;
    localparam int EVT_SPUR_FST_BIT = 2;

    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]        RST_DBG  = 2'h0;
    localparam logic [EVT_W-1:0]  RST_EVT  = 3'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } iccs_bus_t;

    typedef struct packed {
        logic [DATA_W-1:0] pending;
        logic [DATA_W-1:0] enabled;
        logic [DATA_W-1:0] spurious;
        logic [1:0]        debug;
        logic [DATA_W-1:0] rdData;
        logic              fastReq_n;
        logic              normalReq_n;
        logic              eosPulse;
        logic              vectorAck;
        logic [EVT_W-1:0]  evtStatus;
        logic [EVT_W-1:0]  evtMask;
        logic              irq;
    } iccs_state_t;

    localparam iccs_state_t RST_STATE = '{
        pending:     RST_WORD,
        enabled:     RST_WORD,
        spurious:    RST_WORD,
        debug:       RST_DBG,
        rdData:      RST_WORD,
        fastReq_n:   1'h1,
        normalReq_n: 1'h1,
        eosPulse:    1'h0,
        vectorAck:   1'h0,
        evtStatus:   RST_EVT,
        evtMask:     RST_EVT,
        irq:         1'h0
    };

endpackage

// >>> design/iccs_core.sv
// Command and status registers of the vectored interrupt controller.
`timescale 1ns/100ps

module iccs_core (
    input  logic                       clk,
    input  logic                       sys_rst,
    input  iccs_pkg::iccs_bus_t        busReq,
    output logic [iccs_pkg::DATA_W-1:0] rdData,
    input  logic [iccs_pkg::NUM_SRC-1:0] srcTrigger,
    input  logic                       arbFastReq,
    input  logic                       arbNormalReq,
    input  logic                       curValid,
    input  logic [iccs_pkg::SRC_W-1:0] curSourceNum,
    input  logic [iccs_pkg::DATA_W-1:0] srcVector [iccs_pkg::NUM_SRC],
    output logic                       fastRequestOut_n,
    output logic                       normalRequestOut_n,
    output logic                       eosPulse,
    output logic                       vectorAck,
    output logic                       protectionMode,
    output logic [iccs_pkg::NUM_SRC-1:0] pendingView,
    output logic                       irqOut
);

    ////////////////////////////////////////////////////////////////////////////////////////////

    // Set wins over clear in every set/clear word of this block: pending, enable mask and event status.
    function automatic logic [iccs_pkg::DATA_W-1:0] setClr(
        input logic [iccs_pkg::DATA_W-1:0] cur,
        input logic [iccs_pkg::DATA_W-1:0] setBits,
        input logic [iccs_pkg::DATA_W-1:0] clrBits
    );
        setClr = (cur & ~clrBits) | setBits;
    endfunction

    function automatic logic hit(
        input iccs_pkg::iccs_bus_t     req,
        input logic [iccs_pkg::ADDR_W-1:0] ofs
    );
        hit = (req.addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////

    iccs_pkg::iccs_state_t             st_ff;
    iccs_pkg::iccs_state_t             nxt_st;
    logic [iccs_pkg::DATA_W-1:0]       normalVecValue;
    logic [iccs_pkg::DATA_W-1:0]       fastVecValue;
    logic                              fastActive;
    logic [iccs_pkg::DATA_W-1:0]       enaBits;
    logic [iccs_pkg::DATA_W-1:0]       disBits;
    logic [iccs_pkg::DATA_W-1:0]       clrBits;
    logic [iccs_pkg::DATA_W-1:0]       setBits;
    logic [iccs_pkg::EVT_W-1:0]        newEvt;
    logic [iccs_pkg::EVT_W-1:0]        evtClr;
    logic                              normalVecRd;
    logic                              fastVecRd;
    logic [iccs_pkg::DATA_W-1:0]       evtWide;

    // The vector table is indexed by the current number as it stands at the read strobe.
    assign normalVecValue = curValid ? srcVector[curSourceNum]
                                     : st_ff.spurious;
    assign fastActive     = st_ff.pending[iccs_pkg::FAST_SRC] & st_ff.enabled[iccs_pkg::FAST_SRC];
    assign fastVecValue   = fastActive ? srcVector[iccs_pkg::FAST_SRC]
                                       : st_ff.spurious;

    assign normalVecRd = busReq.rd && hit(busReq, iccs_pkg::OFS_NORMAL_VEC);
    assign fastVecRd   = busReq.rd && hit(busReq, iccs_pkg::OFS_FAST_VEC);

    // Commands act only on the written ones, so zero bits leave every source alone.
    assign enaBits = (busReq.wr && hit(busReq, iccs_pkg::OFS_ENABLE_CMD))
                     ? busReq.wdata : iccs_pkg::RST_WORD;
    assign disBits = (busReq.wr && hit(busReq, iccs_pkg::OFS_DISABLE_CMD))
                     ? busReq.wdata : iccs_pkg::RST_WORD;
    assign clrBits = (busReq.wr && hit(busReq, iccs_pkg::OFS_CLEAR_CMD))
                     ? busReq.wdata : iccs_pkg::RST_WORD;
    assign setBits = (busReq.wr && hit(busReq, iccs_pkg::OFS_SET_CMD))
                     ? busReq.wdata : iccs_pkg::RST_WORD;

    assign newEvt = {fastVecRd && !fastActive,
                     normalVecRd && !curValid,
                     busReq.wr && hit(busReq, iccs_pkg::OFS_EOS_CMD)};
    assign evtClr = (busReq.rd && hit(busReq, iccs_pkg::OFS_EVT_STATUS))
                    ? {iccs_pkg::EVT_W{1'b1}} : {iccs_pkg::EVT_W{1'b0}};

    ////////////////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdData    = iccs_pkg::RST_WORD;
        nxt_st.eosPulse  = 1'b0;
        nxt_st.vectorAck = 1'b0;

        // Read data stands in the cycle after the strobe only; other cycles show zero.
        if (busReq.rd) begin
            unique case (busReq.addr)
                iccs_pkg::OFS_NORMAL_VEC:  nxt_st.rdData = normalVecValue;
                iccs_pkg::OFS_FAST_VEC:    nxt_st.rdData = fastVecValue;
                iccs_pkg::OFS_CUR_NUM:     nxt_st.rdData = {27'h0000000, curSourceNum};
                iccs_pkg::OFS_PENDING:     nxt_st.rdData = st_ff.pending;
                iccs_pkg::OFS_ENABLE_MASK: nxt_st.rdData = st_ff.enabled;
                iccs_pkg::OFS_CORE_LINE: begin
                    nxt_st.rdData[iccs_pkg::CORE_FAST_BIT]   = ~st_ff.fastReq_n;
                    nxt_st.rdData[iccs_pkg::CORE_NORMAL_BIT] = ~st_ff.normalReq_n;
                end
                iccs_pkg::OFS_SPURIOUS:    nxt_st.rdData = st_ff.spurious;
                iccs_pkg::OFS_DEBUG:       nxt_st.rdData = {30'h00000000, st_ff.debug};
                iccs_pkg::OFS_EVT_STATUS:  nxt_st.rdData = {29'h00000000, st_ff.evtStatus};
                iccs_pkg::OFS_EVT_MASK:    nxt_st.rdData = {29'h00000000, st_ff.evtMask};
                // Command words and unmapped addresses read as zero.
                default:                   nxt_st.rdData = iccs_pkg::RST_WORD;
            endcase
        end

        // Writes to read-only locations fall through without effect, except a normal vector write under protection, which acknowledges.
        if (busReq.wr) begin
            unique case (busReq.addr)
                iccs_pkg::OFS_SPURIOUS:   nxt_st.spurious = busReq.wdata;
                iccs_pkg::OFS_DEBUG:      nxt_st.debug    = busReq.wdata[1:0];
                iccs_pkg::OFS_EVT_MASK:   nxt_st.evtMask  = busReq.wdata[iccs_pkg::EVT_W-1:0];
                iccs_pkg::OFS_EOS_CMD:    nxt_st.eosPulse = 1'b1;
                default:                  nxt_st.eosPulse = 1'b0;
            endcase
        end

        // Under protection a debugger may read the vector freely; the acknowledge then comes
        // from a write to the vector location instead of from the read.
        if (st_ff.debug[iccs_pkg::DBG_PROTECTION_MODE_BIT]) begin
            nxt_st.vectorAck = busReq.wr && hit(busReq, iccs_pkg::OFS_NORMAL_VEC);
        end else begin
            nxt_st.vectorAck = normalVecRd;
        end

        nxt_st.pending = setClr(st_ff.pending, setBits | srcTrigger, clrBits);
        nxt_st.enabled = setClr(st_ff.enabled, enaBits, disBits);

        // The word is built wide to share the set/clear helper, then cut to the event field.
        evtWide          = setClr({29'h00000000, st_ff.evtStatus}, {29'h00000000, newEvt},
                                  {29'h00000000, evtClr});
        nxt_st.evtStatus = evtWide[iccs_pkg::EVT_W-1:0];
        nxt_st.irq       = |(nxt_st.evtStatus & nxt_st.evtMask);

        // The general mask forces both lines to their inactive high level.
        nxt_st.fastReq_n   = ~(arbFastReq & ~st_ff.debug[iccs_pkg::DBG_GLOBAL_LINE_MASK_BIT]);
        nxt_st.normalReq_n = ~(arbNormalReq & ~st_ff.debug[iccs_pkg::DBG_GLOBAL_LINE_MASK_BIT]);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= iccs_pkg::RST_STATE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdData             = st_ff.rdData;
    assign fastRequestOut_n   = st_ff.fastReq_n;
    assign normalRequestOut_n = st_ff.normalReq_n;
    assign eosPulse           = st_ff.eosPulse;
    assign vectorAck          = st_ff.vectorAck;
    assign protectionMode     = st_ff.debug[iccs_pkg::DBG_PROTECTION_MODE_BIT];
    assign pendingView        = st_ff.pending;
    assign irqOut             = st_ff.irq;

    ////////////////////////////////////////////////////////////////////////////////////////////

    a_pending_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.rd && busReq.addr == iccs_pkg::OFS_PENDING |=> rdData == $past(st_ff.pending))
        else $error("pending view read mismatch");

    a_mask_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.rd && busReq.addr == iccs_pkg::OFS_ENABLE_MASK
        |=> rdData == $past(st_ff.enabled))
        else $error("enable mask read mismatch");

    a_core_line_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.rd && busReq.addr == iccs_pkg::OFS_CORE_LINE
        |=> rdData == {30'h00000000, ~$past(normalRequestOut_n), ~$past(fastRequestOut_n)})
        else $error("core line status mismatch");

    a_enable_cmd: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.wr && busReq.addr == iccs_pkg::OFS_ENABLE_CMD
        |=> st_ff.enabled == ($past(st_ff.enabled) | $past(busReq.wdata)))
        else $error("enable command did not enable");

    a_disable_cmd: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.wr && busReq.addr == iccs_pkg::OFS_DISABLE_CMD
        |=> st_ff.enabled == ($past(st_ff.enabled) & ~$past(busReq.wdata)))
        else $error("disable command did not disable");

    a_clear_cmd: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.wr && busReq.addr == iccs_pkg::OFS_CLEAR_CMD && srcTrigger == '0
        |=> st_ff.pending == ($past(st_ff.pending) & ~$past(busReq.wdata)))
        else $error("clear command mismatch");

    a_set_cmd: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.wr && busReq.addr == iccs_pkg::OFS_SET_CMD
        |=> (st_ff.pending & $past(busReq.wdata)) == $past(busReq.wdata))
        else $error("set command did not set");

    a_eos_pulse: assert property (
        @(posedge clk) disable iff (sys_rst)
        eosPulse == $past(busReq.wr && busReq.addr == iccs_pkg::OFS_EOS_CMD))
        else $error("end of service pulse mismatch");

    a_spurious_store: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.wr && busReq.addr == iccs_pkg::OFS_SPURIOUS
        ##1 busReq.rd && busReq.addr == iccs_pkg::OFS_SPURIOUS
        |=> rdData == $past(busReq.wdata, 2))
        else $error("spurious vector not stored");

    a_normal_spur: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.rd && busReq.addr == iccs_pkg::OFS_NORMAL_VEC && !curValid
        |=> rdData == $past(st_ff.spurious) && st_ff.evtStatus[iccs_pkg::EVT_SPUR_NRM_BIT])
        else $error("spurious normal vector mismatch");

    a_fast_spur: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.rd && busReq.addr == iccs_pkg::OFS_FAST_VEC && !fastActive
        |=> rdData == $past(st_ff.spurious))
        else $error("spurious fast vector mismatch");

    a_protection_mode_ack: assert property (
        @(posedge clk) disable iff (sys_rst)
        protectionMode && normalVecRd |=> !vectorAck)
        else $error("vector read acknowledged under protection");

    a_global_line_mask_lines: assert property (
        @(posedge clk) disable iff (sys_rst)
        st_ff.debug[iccs_pkg::DBG_GLOBAL_LINE_MASK_BIT] |=> fastRequestOut_n && normalRequestOut_n)
        else $error("request line active under general mask");

    a_normal_vec: assert property (
        @(posedge clk) disable iff (sys_rst)
        normalVecRd && curValid |=> rdData == $past(srcVector[curSourceNum]))
        else $error("normal vector mismatch");

    a_cmd_reads_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.rd && busReq.addr >= iccs_pkg::OFS_ENABLE_CMD
        && busReq.addr <= iccs_pkg::OFS_EOS_CMD |=> rdData == '0)
        else $error("command register read not zero");

    // Each command word may touch only its own state; everything else must hold still.
    a_enable_keep: assert property (
        @(posedge clk) disable iff (sys_rst)
        !(busReq.wr && (busReq.addr == iccs_pkg::OFS_ENABLE_CMD
        || busReq.addr == iccs_pkg::OFS_DISABLE_CMD)) |=> $stable(st_ff.enabled))
        else $error("enable state changed without a command");

    a_pending_keep: assert property (
        @(posedge clk) disable iff (sys_rst)
        !(busReq.wr && busReq.addr == iccs_pkg::OFS_SET_CMD) && srcTrigger == '0
        |=> (st_ff.pending & ~$past(st_ff.pending)) == '0)
        else $error("pending bit set without a cause");

    a_ro_pending: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.wr && busReq.addr == iccs_pkg::OFS_PENDING
        |=> st_ff.pending == ($past(st_ff.pending) | $past(srcTrigger)))
        else $error("write to pending view took effect");

    a_eos_event: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.wr && busReq.addr == iccs_pkg::OFS_EOS_CMD
        |=> st_ff.evtStatus[iccs_pkg::EVT_EOS_BIT])
        else $error("end of service event not recorded");

    a_fast_vec: assert property (
        @(posedge clk) disable iff (sys_rst)
        fastVecRd && fastActive |=> rdData == $past(srcVector[iccs_pkg::FAST_SRC]))
        else $error("fast vector mismatch");

    a_fast_spur_evt: assert property (
        @(posedge clk) disable iff (sys_rst)
        fastVecRd && !fastActive |=> st_ff.evtStatus[iccs_pkg::EVT_SPUR_FST_BIT])
        else $error("spurious fast event not recorded");

    a_ack_on_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        !protectionMode && normalVecRd |=> vectorAck)
        else $error("vector read not acknowledged");

    a_ack_on_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        protectionMode && busReq.wr && busReq.addr == iccs_pkg::OFS_NORMAL_VEC
        |=> vectorAck)
        else $error("vector write not acknowledged under protection");

    a_protection_mode_store: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.wr && busReq.addr == iccs_pkg::OFS_DEBUG
        |=> protectionMode == $past(busReq.wdata[iccs_pkg::DBG_PROTECTION_MODE_BIT]))
        else $error("protection bit not stored");

    a_fast_follow: assert property (
        @(posedge clk) disable iff (sys_rst)
        !st_ff.debug[iccs_pkg::DBG_GLOBAL_LINE_MASK_BIT] |=> fastRequestOut_n == !$past(arbFastReq))
        else $error("fast line does not follow its request");

    a_normal_follow: assert property (
        @(posedge clk) disable iff (sys_rst)
        !st_ff.debug[iccs_pkg::DBG_GLOBAL_LINE_MASK_BIT] |=> normalRequestOut_n == !$past(arbNormalReq))
        else $error("normal line does not follow its request");

    a_spurious_keep: assert property (
        @(posedge clk) disable iff (sys_rst)
        !(busReq.wr && busReq.addr == iccs_pkg::OFS_SPURIOUS) |=> $stable(st_ff.spurious))
        else $error("spurious vector changed without a write");

    a_evt_read_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.rd && busReq.addr == iccs_pkg::OFS_EVT_STATUS
        |=> st_ff.evtStatus == '0)
        else $error("event status not cleared by read");

    a_irq_level: assert property (
        @(posedge clk) disable iff (sys_rst)
        irqOut == |(st_ff.evtStatus & st_ff.evtMask))
        else $error("interrupt output mismatch");

    a_rd_idle_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        !busReq.rd |=> rdData == '0)
        else $error("read data not zero outside a read");

    a_mask_ro_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        busReq.wr && busReq.addr == iccs_pkg::OFS_ENABLE_MASK
        |=> $stable(st_ff.enabled))
        else $error("write to mask view took effect");

endmodule

// >>> tb/iccs_core_model.sv
// Behavioural model of the processor core that receives the request lines.
`timescale 1ns/100ps

module iccs_core_model #(
    parameter int HANDLER_CYC = 4
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic fastRequestOut_n,
    input  wire logic normalRequestOut_n,
    output logic      handlerDone,
    output logic      fastSeen
);
    int unsigned svcCnt;

    ////////////////////////////////////////////////////////////////////////
    // The handler runs a fixed time after the normal line goes active, then
    // asks the bench to write the end-of-service command on its behalf.
    always @(posedge clk) begin
        if (sys_rst) begin
            svcCnt      <= 0;
            handlerDone <= 1'h0;
            fastSeen    <= 1'h0;
        end else begin
            if (!fastRequestOut_n) begin
                fastSeen <= 1'h1;
            end
            if (!normalRequestOut_n && svcCnt < HANDLER_CYC) begin
                svcCnt <= svcCnt + 1;
            end
            handlerDone <= (svcCnt == HANDLER_CYC);
        end
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench of the interrupt command and status registers.
`timescale 1ns/100ps

module tb_top;
    logic                clk;
    logic                sys_rst;
    iccs_pkg::iccs_bus_t busReq;
    logic [31:0]         rdData;
    logic [31:0]         srcTrigger;
    logic                arbFastReq;
    logic                arbNormalReq;
    logic                curValid;
    logic [4:0]          curSourceNum;
    logic [31:0]         srcVec [iccs_pkg::NUM_SRC];
    logic                fastRequestOut_n;
    logic                normalRequestOut_n;
    logic                eosPulse;
    logic                vectorAck;
    logic                protectionMode;
    logic [31:0]         pendingView;
    logic                irqOut;
    logic                handlerDone;
    logic                fastSeen;
    logic                ackSeen;
    logic [31:0]         rdVal;
    int                  n_errors;
    int                  num_checks;

    iccs_core uut (.clk(clk), .sys_rst(sys_rst), .busReq(busReq), .rdData(rdData),
        .srcTrigger(srcTrigger), .arbFastReq(arbFastReq), .arbNormalReq(arbNormalReq),
        .curValid(curValid), .curSourceNum(curSourceNum), .srcVector(srcVec),
        .fastRequestOut_n(fastRequestOut_n), .normalRequestOut_n(normalRequestOut_n),
        .eosPulse(eosPulse), .vectorAck(vectorAck), .protectionMode(protectionMode),
        .pendingView(pendingView), .irqOut(irqOut));

    iccs_core_model #(.HANDLER_CYC(4)) core (.clk(clk), .sys_rst(sys_rst),
        .fastRequestOut_n(fastRequestOut_n), .normalRequestOut_n(normalRequestOut_n),
        .handlerDone(handlerDone), .fastSeen(fastSeen));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Checks made: %0d, mismatches: %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq.addr  <= a;
        busReq.wdata <= d;
        busReq.wr    <= 1'h1;
        @(posedge clk);
        busReq.wr <= 1'h0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        busReq.addr <= a;
        busReq.rd   <= 1'h1;
        @(posedge clk);
        busReq.rd <= 1'h0;
        #1;
        ackSeen = vectorAck;
        check(rdData, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_errors = 0;
        num_checks = 0;
        repeat (5000) @(posedge clk);
        n_errors++;
        $display("BAD at %0t: run did not finish in time", $time);
        give_verdict();
    end

    initial begin
        sys_rst = 1'h1;
        busReq = '0;
        srcTrigger = '0;
        arbFastReq = 1'h0;
        arbNormalReq = 1'h0;
        curValid = 1'h0;
        curSourceNum = '0;
        for (int i = 0; i < iccs_pkg::NUM_SRC; i++) begin
            srcVec[i] = 32'hA000_0000 | 32'(i << 2);
        end
        repeat (16) @(posedge clk);
        sys_rst <= 1'h0;
        #1;
        check({fastRequestOut_n, normalRequestOut_n, irqOut}, 32'h6);
        rd_chk(iccs_pkg::OFS_PENDING, 32'h0);
        rd_chk(iccs_pkg::OFS_ENABLE_MASK, 32'h0);
        rd_chk(iccs_pkg::OFS_SPURIOUS, 32'h0);
        rd_chk(iccs_pkg::OFS_DEBUG, 32'h0);
        // Enable, disable and read-only protection of the mask view.
        wr_reg(iccs_pkg::OFS_ENABLE_CMD, 32'h0000_0005);
        wr_reg(iccs_pkg::OFS_ENABLE_CMD, 32'hA000_0000);
        rd_chk(iccs_pkg::OFS_ENABLE_MASK, 32'hA000_0005);
        wr_reg(iccs_pkg::OFS_DISABLE_CMD, 32'h0000_0004);
        rd_chk(iccs_pkg::OFS_ENABLE_MASK, 32'hA000_0001);
        wr_reg(iccs_pkg::OFS_ENABLE_MASK, 32'hFFFF_FFFF);
        rd_chk(iccs_pkg::OFS_ENABLE_MASK, 32'hA000_0001);
        rd_chk(iccs_pkg::OFS_ENABLE_CMD, 32'h0);
        rd_chk(12'h1F0, 32'h0);
        // Pending set, clear and source pulses.
        wr_reg(iccs_pkg::OFS_SET_CMD, 32'h8000_0003);
        rd_chk(iccs_pkg::OFS_PENDING, 32'h8000_0003);
        wr_reg(iccs_pkg::OFS_CLEAR_CMD, 32'h0000_0001);
        check(pendingView, 32'h8000_0002);
        @(posedge clk);
        srcTrigger <= 32'h0000_0020;
        @(posedge clk);
        srcTrigger <= 32'h0;
        #1;
        check(pendingView, 32'h8000_0022);
        // Back-to-back write and read of the spurious store.
        @(posedge clk);
        busReq <= '{addr: iccs_pkg::OFS_SPURIOUS, wdata: 32'h5A5A_0F0F, wr: 1'h1, rd: 1'h0};
        @(posedge clk);
        busReq <= '{addr: iccs_pkg::OFS_SPURIOUS, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
        @(posedge clk);
        busReq.rd <= 1'h0;
        #1;
        check(rdData, 32'h5A5A_0F0F);
        // Vector reads: spurious store, current source, fast source.
        wr_reg(iccs_pkg::OFS_SPURIOUS, 32'h1234_5678);
        rd_chk(iccs_pkg::OFS_SPURIOUS, 32'h1234_5678);
        rd_chk(iccs_pkg::OFS_NORMAL_VEC, 32'h1234_5678);
        rd_chk(iccs_pkg::OFS_FAST_VEC, 32'h1234_5678);
        @(posedge clk);
        curValid <= 1'h1;
        curSourceNum <= 5'h07;
        rd_chk(iccs_pkg::OFS_NORMAL_VEC, 32'hA000_001C);
        check(ackSeen, 32'h1);
        rd_chk(iccs_pkg::OFS_CUR_NUM, 32'h7);
        wr_reg(iccs_pkg::OFS_SET_CMD, 32'h0000_0001);
        rd_chk(iccs_pkg::OFS_FAST_VEC, 32'hA000_0000);
        // Protection mode moves the acknowledge from the read to a write.
        wr_reg(iccs_pkg::OFS_DEBUG, 32'h0000_0001);
        check(protectionMode, 32'h1);
        rd_chk(iccs_pkg::OFS_NORMAL_VEC, 32'hA000_001C);
        check(ackSeen, 32'h0);
        wr_reg(iccs_pkg::OFS_NORMAL_VEC, 32'h0);
        check(vectorAck, 32'h1);
        wr_reg(iccs_pkg::OFS_DEBUG, 32'h0000_0000);
        // Request lines and their status view.
        @(posedge clk);
        arbFastReq <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        check({fastRequestOut_n, normalRequestOut_n}, 32'h1);
        rd_chk(iccs_pkg::OFS_CORE_LINE, 32'h1);
        @(posedge clk);
        arbNormalReq <= 1'h1;
        rd_chk(iccs_pkg::OFS_CORE_LINE, 32'h3);
        check(fastSeen, 32'h1);
        // Events: one masked, one unmasked, cleared by reading.
        @(posedge clk);
        curValid <= 1'h0;
        rd_chk(iccs_pkg::OFS_EVT_STATUS, 32'h6);
        wr_reg(iccs_pkg::OFS_EVT_MASK, 32'h1);
        rd_chk(iccs_pkg::OFS_NORMAL_VEC, 32'h1234_5678);
        check(irqOut, 32'h0);
        for (int i = 0; i < 50 && !handlerDone; i++) begin
            @(posedge clk);
        end
        if (handlerDone !== 1'h1) begin
            n_errors++;
            $display("BAD at %0t: handler never finished", $time);
            give_verdict();
        end
        wr_reg(iccs_pkg::OFS_EOS_CMD, 32'hDEAD_BEEF);
        check({eosPulse, irqOut}, 32'h3);
        rd_chk(iccs_pkg::OFS_EVT_STATUS, 32'h3);
        check(irqOut, 32'h0);
        rd_chk(iccs_pkg::OFS_EVT_MASK, 32'h1);
        // General mask holds both lines inactive while sources still request.
        wr_reg(iccs_pkg::OFS_DEBUG, 32'h0000_0002);
        @(posedge clk);
        #1;
        check({fastRequestOut_n, normalRequestOut_n}, 32'h3);
        rd_chk(iccs_pkg::OFS_CORE_LINE, 32'h0);
        rd_chk(iccs_pkg::OFS_DEBUG, 32'h2);
        wr_reg(iccs_pkg::OFS_DEBUG, 32'h0000_0000);
        @(posedge clk);
        #1;
        check({fastRequestOut_n, normalRequestOut_n}, 32'h0);
        give_verdict();
    end
endmodule
